// *** include/timer_ch3_params.svh ***
/*
 timer channel 3 i/o control: register offsets, field positions, reset values.
 assumes inclusion by bare name from the design file and the package.
*/
`ifndef TIMER_CH3_PARAMS_SVH
`define TIMER_CH3_PARAMS_SVH

// apb byte addresses, one aligned word each
`define ADDR_W 8
`define ADDR_IO_CONTROL 8'h00
`define ADDR_MODE 8'h04
`define ADDR_GR_A 8'h08
`define ADDR_GR_C 8'h0C
`define ADDR_INT_STATUS 8'h10
`define ADDR_INT_MASK 8'h14
`define ADDR_PIN_STATE 8'h18

// field positions inside the io control byte and the mode register
`define FIELD_W 4
`define FIELD_A_LSB 0
`define FIELD_C_LSB 4
`define MODE_BUFFER_BIT 0

// widths and reset values
`define CNT_W 16
`define IO_CONTROL_RESET 8'h00
`define MODE_RESET 1'b0
`define GR_RESET 16'hFFFF
`define INT_RESET 2'h0

`endif

// *** include/timer_ch3_pkg.sv ***
/*
 types shared by the channel 3 i/o control block.
 assumes timer_ch3_params.svh is on the include path.
*/
`include "timer_ch3_params.svh"

package timer_ch3_pkg;

   // low two bits of an io field: action at compare match
   typedef enum logic [1:0] {
      ACT_NONE = 2'b00,
      ACT_LOW = 2'b01,
      ACT_HIGH = 2'b10,
      ACT_TOGGLE = 2'b11
   } act_e;

   // one 4-bit io select field, bit 3 down to bit 0
   typedef struct packed {
      logic capture; // bit 3: capture register, not compare
      logic level; // bit 2: initial level, or channel 4 source
      act_e act; // bits 1..0
   } io_field_s;

   typedef logic [`CNT_W-1:0] count_t;

   // sampled edges of one capture pin
   typedef struct packed {
      logic rise;
      logic fall;
   } pin_edge_s;

endpackage

// *** hw/timer_ch3_io_control.sv ***
/*
 i/o control for timer channel 3: general registers a and c as output
 compare or input capture, their pins, interrupt flags, apb register file.
 assumes the channel counter and channel 4 count pulses come from logic on
 pclk; pin inputs are asynchronous and pass a three-stage synchroniser.
*/
// Design decisions made here: the register offsets and register access over APB.
`include "timer_ch3_params.svh"

module timer_ch3_io_control (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire timer_ch3_pkg::count_t ch3_counter,
   input wire logic ch4_count_up,
   input wire logic ch4_count_down,
   input wire logic ch3_pin_a_in,
   output logic ch3_pin_a_out,
   output logic ch3_pin_a_oe,
   input wire logic ch3_pin_c_in,
   output logic ch3_pin_c_out,
   output logic ch3_pin_c_oe,
   output logic irq
);
   import timer_ch3_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // functions

   // compare field that drives its pin
   function automatic logic field_drives(input io_field_s f);
      field_drives = !f.capture && (f.act != ACT_NONE);
   endfunction

   // capture trigger chosen by the field
   function automatic logic capture_hit(input io_field_s f, input pin_edge_s e,
                                        input logic ch4_tick);
      logic hit;
      hit = 1'b0;
      if (f.level) begin
         hit = ch4_tick;
      end else if (f.act[1]) begin
         hit = e.rise | e.fall;
      end else if (f.act[0]) begin
         hit = e.fall;
      end else begin
         hit = e.rise;
      end
      capture_hit = f.capture && hit;
   endfunction

   // address compare, used for the write decodes only
   function automatic logic hit_addr(input logic [`ADDR_W-1:0] a,
                                     input logic [`ADDR_W-1:0] b);
      hit_addr = (a == b);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // apb slave

   logic [7:0] channel3_io_control_high;
   logic reg_a_buffer_mode;
   logic [1:0] int_status;
   logic [1:0] int_mask;
   logic [1:0] evt;
   logic [1:0] pin_state;
   logic [1:0] wr_gr;
   logic [31:0] read_value;
   logic mapped;
   logic access;
   logic wr;
   logic wr_io;
   logic wr_mode;
   logic [7:0] next_io;
   logic next_buffer;

   assign access = psel && penable && pready;
   assign wr = access && pwrite && mapped;
   assign wr_io = wr && hit_addr(paddr, `ADDR_IO_CONTROL);
   assign wr_mode = wr && hit_addr(paddr, `ADDR_MODE);
   assign wr_gr[0] = wr && hit_addr(paddr, `ADDR_GR_A);
   assign wr_gr[1] = wr && hit_addr(paddr, `ADDR_GR_C);
   assign next_io = wr_io ? pwdata[7:0] : channel3_io_control_high;
   assign next_buffer = wr_mode ? pwdata[`MODE_BUFFER_BIT] : reg_a_buffer_mode;

   // read mux and address map
   always_comb begin
      mapped = 1'b1;
      read_value = 32'h00000000;
      case (paddr)
         `ADDR_IO_CONTROL: read_value = {24'h000000, channel3_io_control_high};
         `ADDR_MODE: read_value = {31'h00000000, reg_a_buffer_mode};
         `ADDR_GR_A: read_value = {16'h0000, ch[0].gr};
         `ADDR_GR_C: read_value = {16'h0000, ch[1].gr};
         `ADDR_INT_STATUS: read_value = {30'h00000000, int_status};
         `ADDR_INT_MASK: read_value = {30'h00000000, int_mask};
         `ADDR_PIN_STATE: read_value = {30'h00000000, pin_state};
         default: mapped = 1'b0;
      endcase
   end

   // one wait state, answer registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h00000000 : read_value;
            pslverr <= !mapped;
         end else begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
         end
      end
   end

   // control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel3_io_control_high <= `IO_CONTROL_RESET;
         reg_a_buffer_mode <= `MODE_RESET;
         int_mask <= `INT_RESET;
      end else begin
         channel3_io_control_high <= next_io;
         reg_a_buffer_mode <= next_buffer;
         if (wr && hit_addr(paddr, `ADDR_INT_MASK)) begin
            int_mask <= pwdata[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // channels: i = 0 register a, i = 1 register c

   logic [1:0] pin_in;
   logic ch4_tick;
   assign pin_in = {ch3_pin_c_in, ch3_pin_a_in};
   assign ch4_tick = ch4_count_up | ch4_count_down;

   for (genvar i = 0; i < 2; i++) begin : ch
      io_field_s fld;
      io_field_s next_fld;
      pin_edge_s edges;
      logic blocked;
      logic next_blocked;
      logic eq;
      logic eq_prev;
      logic match_evt;
      logic cap_evt;
      logic [2:0] sync;
      logic filt;
      logic [`CNT_W-1:0] gr;
      logic level;
      logic oe;

      assign fld = io_field_s'(channel3_io_control_high[4*i +: `FIELD_W]);
      assign next_fld = io_field_s'(next_io[4*i +: `FIELD_W]);
      assign blocked = (i == 1) && reg_a_buffer_mode;
      assign next_blocked = (i == 1) && next_buffer;

      // three-stage pin synchroniser
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            sync <= 3'h0;
         end else begin
            sync <= {sync[1:0], pin_in[i]};
         end
      end
      // filtered level: a change counts once stages two and three agree
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            filt <= 1'b0;
         end else if (sync[1] == sync[2]) begin
            filt <= sync[2];
         end
      end
      assign edges.rise = (sync[1] == sync[2]) && sync[2] && !filt;
      assign edges.fall = (sync[1] == sync[2]) && !sync[2] && filt;

      assign eq = (ch3_counter == gr);
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            eq_prev <= 1'b0;
         end else begin
            eq_prev <= eq;
         end
      end
      assign match_evt = field_drives(fld) && !blocked && eq && !eq_prev;
      assign cap_evt = capture_hit(fld, edges, ch4_tick) && !blocked;
      assign evt[i] = match_evt | cap_evt;

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            gr <= `GR_RESET;
         end else if (cap_evt) begin
            gr <= ch3_counter;
         end else if (wr_gr[i]) begin
            gr <= pwdata[`CNT_W-1:0];
         end
      end

      // enable only for driving compare codes
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            oe <= 1'b0;
         end else begin
            oe <= field_drives(next_fld) && !next_blocked;
         end
      end

      // pin level: initial level on write, then match actions
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            level <= 1'b0;
         end else if (wr_io && field_drives(next_fld)) begin
            level <= next_fld.level;
         end else if (match_evt) begin
            case (fld.act)
               ACT_LOW: level <= 1'b0;
               ACT_HIGH: level <= 1'b1;
               ACT_TOGGLE: level <= !level;
               default: level <= level;
            endcase
         end
      end
      assign pin_state[i] = filt;
   end

   assign ch3_pin_a_out = ch[0].level;
   assign ch3_pin_a_oe = ch[0].oe;
   assign ch3_pin_c_out = ch[1].level;
   assign ch3_pin_c_oe = ch[1].oe;

   ////////////////////////////////////////////////////////////////////////
   // interrupts

   // sticky flags, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status <= `INT_RESET;
      end else if (wr && hit_addr(paddr, `ADDR_INT_STATUS)) begin
         int_status <= (int_status & ~pwdata[1:0]) | evt;
      end else begin
         int_status <= int_status | evt;
      end
   end

   // level interrupt from unmasked flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_status & int_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_pin_disabled: assert property (
      (next_io[1:0] == 2'b00 || next_io[3]) |=> !ch3_pin_a_oe)
      else $error("pin a driven under a non-driving code");

   a_initial_high: assert property (
      wr_io && pwdata[3:2] == 2'b01 && pwdata[1:0] != 2'b00
      |=> ch3_pin_a_out && ch3_pin_a_oe)
      else $error("pin a initial level not high");

   a_match_low: assert property (
      ch[0].match_evt && ch[0].fld.act == ACT_LOW && !wr_io |=> !ch3_pin_a_out)
      else $error("pin a not low after match");

   a_match_high: assert property (
      ch[0].match_evt && ch[0].fld.act == ACT_HIGH && !wr_io |=> ch3_pin_a_out)
      else $error("pin a not high after match");

   a_match_toggle: assert property (
      ch[0].match_evt && ch[0].fld.act == ACT_TOGGLE && !wr_io
      |=> ch3_pin_a_out != $past(ch3_pin_a_out))
      else $error("pin a did not toggle on match");

   a_capture_value: assert property (
      ch[0].cap_evt |=> ch[0].gr == $past(ch3_counter))
      else $error("capture did not copy the counter");

   a_c_blocked: assert property (
      reg_a_buffer_mode |-> !evt[1] ##1 (!ch3_pin_c_oe || !reg_a_buffer_mode))
      else $error("register c active in buffer mode");

   a_irq_level: assert property (
      ##1 irq == |($past(int_status) & $past(int_mask)))
      else $error("interrupt level does not follow flags");

   a_fall_capture: assert property (
      channel3_io_control_high[3:0] == 4'h9 && ch[0].edges.fall |-> ch[0].cap_evt)
      else $error("falling pin edge not captured");

   a_both_capture: assert property (
      channel3_io_control_high[3:1] == 3'b101 && (ch[0].edges.rise || ch[0].edges.fall)
      |-> ch[0].cap_evt)
      else $error("pin edge missed under both-edge code");

   a_count_capture: assert property (
      channel3_io_control_high[3:2] == 2'b11 && ch4_tick
      |=> ch[0].gr == $past(ch3_counter))
      else $error("count step did not capture");

   a_count_only: assert property (
      channel3_io_control_high[3:2] == 2'b11 && !ch4_tick |-> !evt[0])
      else $error("capture without a count step");

   a_c_match_high: assert property (
      ch[1].match_evt && ch[1].fld.act == ACT_HIGH && !wr_io |=> ch3_pin_c_out)
      else $error("pin c not high after match");

   a_match_entry: assert property (
      ch3_counter == ch[0].gr && !ch[0].eq_prev && channel3_io_control_high[3:0] == 4'h3
      |-> evt[0])
      else $error("compare match not flagged");

endmodule

// *** verif/timer_ch3_pin_model.sv ***
/*
 far side of the channel 3 pins: one external source for each pin.
 assumes oe high means the block drives the pin; the bench sets the sources.
*/
module timer_ch3_pin_model (
   input wire logic a_oe,
   input wire logic a_out,
   input wire logic a_drv,
   input wire logic c_oe,
   input wire logic c_out,
   input wire logic c_drv,
   output logic a_in,
   output logic c_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // pin level resolution
   // wire level: the block while driving, else the outside source
   assign a_in = a_oe ? a_out : a_drv;
   assign c_in = c_oe ? c_out : c_drv;
endmodule

// *** verif/timer_ch3_io_control_test.sv ***
/*
 self-checking bench for the channel 3 i/o control block.
 assumes the package, the design and the pin model are compiled first.
*/
`include "timer_ch3_params.svh"
module timer_ch3_io_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   import timer_ch3_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, up = 0, down = 0, irq;
   count_t cnt = 16'h0000;
   logic a_in, a_out, a_oe, c_in, c_out, c_oe, a_drv = 0, c_drv = 0;
   logic [31:0] seed = 32'h1F556FBF;
   int fails = 0, num_checks = 0, cycles = 0;
   ////////////////////////////////////////////////////////////////////////
   timer_ch3_io_control i_timer_ch3_io_control (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch3_counter(cnt),
      .ch4_count_up(up), .ch4_count_down(down), .ch3_pin_a_in(a_in),
      .ch3_pin_a_out(a_out), .ch3_pin_a_oe(a_oe), .ch3_pin_c_in(c_in),
      .ch3_pin_c_out(c_out), .ch3_pin_c_oe(c_oe), .irq(irq));
   timer_ch3_pin_model i_timer_ch3_pin_model (.a_oe(a_oe), .a_out(a_out),
      .a_drv(a_drv), .c_oe(c_oe), .c_out(c_out), .c_drv(c_drv), .a_in(a_in), .c_in(c_in));
   // clock and hang guard
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // pin level after a match: low, high, or initial level inverted
   function automatic logic exp_level(logic [3:0] c);
      return (c[1:0] == 2'b11) ? ~c[2] : c[1];
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one apb transfer; pready and read data taken at the rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] v, g;
      logic [3:0] code;
      repeat (5) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      // reset values and an unmapped address
      apb(0, `ADDR_GR_A, 0);
      chk(rd, 32'hFFFF);
      apb(0, 8'h1C, 0);
      chk({rd[30:0], err}, 32'h1);
      $display("test reset done");
      // compare codes, every one of the eight
      apb(1, `ADDR_INT_MASK, 32'h3);
      for (int k = 0; k < 8; k++) begin
         code = k[3:0];
         v = 16'(rnd());
         cnt <= v ^ 16'h00F0;
         apb(1, `ADDR_GR_A, {16'h0, v});
         apb(1, `ADDR_IO_CONTROL, {28'h0, code});
         wait_n(2);
         chk(a_oe, code[1:0] != 0);
         if (a_oe === 1'b1) chk(a_out, code[2]);
         cnt <= v;
         wait_n(3);
         if (code[1:0] != 0) chk(a_out, exp_level(code));
         apb(0, `ADDR_INT_STATUS, 0);
         chk({rd[0], irq}, {2{code[1:0] != 0}});
         apb(1, `ADDR_INT_STATUS, 32'h1);
         wait_n(1);
         chk(irq, 0);
      end
      $display("test compare done");
      // pin capture: rising, falling, both edges
      for (int k = 8; k < 12; k++) begin
         code = k[3:0];
         a_drv <= 0;
         apb(1, `ADDR_IO_CONTROL, {28'h0, code});
         wait_n(6);
         chk(a_oe, 0);
         g = 16'(rnd());
         apb(1, `ADDR_GR_A, {16'h0, g});
         v = 16'(rnd());
         cnt <= v;
         a_drv <= 1;
         wait_n(6);
         apb(0, `ADDR_PIN_STATE, 0);
         chk(rd, 32'h1);
         if (code != 4'h9) g = v;
         apb(0, `ADDR_GR_A, 0);
         chk(rd, {16'h0, g});
         v = 16'(rnd());
         cnt <= v;
         a_drv <= 0;
         wait_n(6);
         if (code != 4'h8) g = v;
         apb(0, `ADDR_GR_A, 0);
         chk(rd, {16'h0, g});
      end
      $display("test capture done");
      // channel 4 count steps, pin edges ignored
      for (int k = 12; k < 16; k++) begin
         apb(1, `ADDR_IO_CONTROL, k);
         v = 16'(rnd());
         cnt <= v;
         a_drv <= ~a_drv;
         wait_n(6);
         apb(0, `ADDR_GR_A, 0);
         chk(rd, {16'h0, g});
         up <= k[0];
         down <= ~k[0];
         @(posedge pclk);
         up <= 0;
         down <= 0;
         wait_n(3);
         apb(0, `ADDR_GR_A, 0);
         chk(rd, {16'h0, v});
         g = v;
      end
      $display("test count source done");
      // register c field, blocked by buffer mode
      apb(1, `ADDR_INT_STATUS, 32'h3);
      v = 16'(rnd());
      cnt <= v ^ 16'h0F00;
      apb(1, `ADDR_GR_C, {16'h0, v});
      apb(1, `ADDR_MODE, 32'h1);
      apb(1, `ADDR_IO_CONTROL, 32'h20);
      cnt <= v;
      wait_n(3);
      apb(0, `ADDR_INT_STATUS, 0);
      chk({c_oe, rd[1:0], irq}, 4'h0);
      cnt <= v ^ 16'h0F00;
      apb(1, `ADDR_MODE, 32'h0);
      apb(1, `ADDR_IO_CONTROL, 32'h20);
      chk({c_oe, c_out}, 2'b10);
      cnt <= v;
      wait_n(3);
      apb(0, `ADDR_INT_STATUS, 0);
      chk({c_out, rd[1], irq}, 3'b111);
      $display("test register c done");
      report_and_stop();
   end
endmodule
